// >>> hdl/cdm_cfg.svh
// constants for the status word and data memory map block
`ifndef CDM_CFG_SVH
`define CDM_CFG_SVH
`define CDM_STATUS_ADDR 8'hD0
`define CDM_STACK_ADDR 8'h81
`define CDM_STATUS_RST 8'h00
`define CDM_STACK_RST 8'h07
`define CDM_BIT_BASE 4'h2
`define CDM_CARRY 7
`define CDM_AUX 6
`define CDM_UFLAG0 5
`define CDM_BS_HI 4
`define CDM_BS_LO 3
`define CDM_OVF 2
`define CDM_UFLAG1 1
`define CDM_PAR 0
`define CDM_BYTE_MAX 16'h00FF
`define CDM_LOCK_16K 16'h3FFF
`define CDM_LOCK_8K 16'h1FFF
`define CDM_LOCK_4K 16'h0FFF
`endif

// >>> hdl/cdm_core.sv
// status word, stack pointer, internal and expansion ram, address decode
`timescale 1ns/1ps
`include "cdm_cfg.svh"

// Functional notes
// - carry set on add carry or subtract borrow, cleared by other arithmetic.
// - aux carry set on nibble carry or borrow, cleared by other arithmetic.
// - status bits 5 and 1 are software flags untouched by hardware.
// - bank select 4:3 picks bank base 0x00, 0x08, 0x10 or 0x18.
// - overflow set on signed overflow of add, add with carry, subtract.
// - overflow set when a product exceeds 255.
// - overflow set when dividing by zero.
// - those five instructions clear overflow otherwise.
// - status bit 0 is read-only accumulator parity, one when odd.
// - status word at 0xD0, byte and bit access, resets to zero.
// - 256 bytes internal ram; lower half direct and indirect.
// - direct access above 0x7F goes to special registers.
// - indirect access above 0x7F reaches upper ram half.
// - 0x00-0x1F are four banks of eight registers, one active.
// - indirect pointer comes from register 0 or 1 of active bank.
// - bytes 0x20-0x2F form bit addresses 0x00-0x7F.
// - bit or byte access chosen by operation, not address.
// - push increments pointer then stores at new location.
// - reset loads stack pointer with 0x07.
// - code reads go to flash; external moves to expansion ram or flash.
// - last code byte is the lock byte per flash size.
// - 256 expansion ram bytes reached by external moves.
module cdm_core import cdm_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// datapath request side
	input wire cdm_req_t req_i,
	input wire logic [7:0] acc_i,
	input wire logic flash_wen_i,
	input wire cdm_fsz_t fsz_i,
	// answers and forwarded accesses
	output cdm_rsp_t rsp_o,
	output cdm_ext_t sfr_o,
	output cdm_ext_t flash_o,
	// state views
	output logic [7:0] status_o,
	output logic [7:0] stack_ptr_o
);
	logic [7:0] status_ff, nxt_status;
	logic [7:0] stack_ptr_ff, nxt_stack_ptr;
	cdm_rsp_t rsp_ff, nxt_rsp;
	cdm_ext_t sfr_ff, nxt_sfr;
	cdm_ext_t fl_ff, nxt_fl;
	logic [7:0] iram_ff [256];
	logic [7:0] exp_ram_ff [256];
	logic iwe, xwe;
	logic [7:0] iwa, iwd, xwa, xwd;
	logic [1:0] bank;
	logic [7:0] ptr, ea, byte_a, cur;
	logic [2:0] bpos;
	logic cin;
	logic [8:0] s9;
	logic [4:0] s5;
	logic [15:0] prod, lock_a;

	assign bank = status_ff[`CDM_BS_HI:`CDM_BS_LO];

	always_comb begin
		nxt_status = status_ff;
		nxt_stack_ptr = stack_ptr_ff;
		nxt_rsp = '0;
		nxt_sfr = '0;
		nxt_fl = '0;
		iwe = 1'b0;
		iwa = '0;
		iwd = '0;
		xwe = 1'b0;
		xwa = '0;
		xwd = '0;
		s9 = '0;
		s5 = '0;
		prod = '0;
		// pointer register of the active bank
		ptr = iram_ff[{3'b000, bank, 2'b00, req_i.addr[0]}];
		case (req_i.am)
			AM_INDIRECT: ea = ptr;
			AM_REG: ea = {3'b000, bank, req_i.addr[2:0]};
			default: ea = req_i.addr;
		endcase
		// bit address: lower half maps into 0x20-0x2F, upper to sfr bases
		if (!req_i.addr[7]) begin
			byte_a = {`CDM_BIT_BASE, req_i.addr[6:3]};
		end else begin
			byte_a = {req_i.addr[7:3], 3'b000};
		end
		bpos = req_i.addr[2:0];
		cur = iram_ff[byte_a];
		cin = (req_i.alu != ALU_ADD) && status_ff[`CDM_CARRY];
		case (fsz_i)
			FSZ_16K: lock_a = `CDM_LOCK_16K;
			FSZ_8K: lock_a = `CDM_LOCK_8K;
			default: lock_a = `CDM_LOCK_4K;
		endcase
		nxt_rsp.valid = req_i.valid && (req_i.op != OP_NONE);
		if (req_i.valid) begin
			case (req_i.op)
				OP_RD, OP_WR: begin
					// direct upper half is sfr space, never upper ram
					if (req_i.am == AM_DIRECT && req_i.addr[7]) begin
						if (req_i.addr == `CDM_STATUS_ADDR) begin
							nxt_rsp.data = status_ff;
							if (req_i.op == OP_WR) begin
								nxt_status[7:1] = req_i.wdata[7:1];
							end
						end else if (req_i.addr == `CDM_STACK_ADDR) begin
							nxt_rsp.data = stack_ptr_ff;
							if (req_i.op == OP_WR) begin
								nxt_stack_ptr = req_i.wdata;
							end
						end else begin
							nxt_rsp.foreign = 1'b1;
							nxt_sfr.valid = 1'b1;
							nxt_sfr.we = (req_i.op == OP_WR);
							nxt_sfr.addr = {8'h00, req_i.addr};
							nxt_sfr.wdata = req_i.wdata;
						end
					end else begin
						nxt_rsp.data = iram_ff[ea];
						iwe = (req_i.op == OP_WR);
						iwa = ea;
						iwd = req_i.wdata;
					end
				end
				// bit operation chosen by opcode, whatever the address
				OP_BIT_RD, OP_BIT_WR: begin
					if (!req_i.addr[7]) begin
						nxt_rsp.bit_val = cur[bpos];
						iwe = (req_i.op == OP_BIT_WR);
						iwa = byte_a;
						iwd = cur;
						iwd[bpos] = req_i.bit_val;
					end else if (byte_a == `CDM_STATUS_ADDR) begin
						nxt_rsp.bit_val = status_ff[bpos];
						// parity bit ignores writes
						if (req_i.op == OP_BIT_WR && bpos != 3'(`CDM_PAR)) begin
							nxt_status[bpos] = req_i.bit_val;
						end
					end else begin
						nxt_rsp.foreign = 1'b1;
						nxt_sfr.valid = 1'b1;
						nxt_sfr.we = (req_i.op == OP_BIT_WR);
						nxt_sfr.is_bit = 1'b1;
						nxt_sfr.addr = {8'h00, req_i.addr};
						nxt_sfr.bit_val = req_i.bit_val;
					end
				end
				OP_PUSH: begin
					nxt_stack_ptr = stack_ptr_ff + 8'h01;
					iwe = 1'b1;
					iwa = nxt_stack_ptr;
					iwd = req_i.wdata;
				end
				OP_POP: begin
					nxt_rsp.data = iram_ff[stack_ptr_ff];
					nxt_stack_ptr = stack_ptr_ff - 8'h01;
				end
				OP_ARITH: begin
					case (req_i.alu)
						ALU_SUB_BR: begin
							s9 = {1'b0, req_i.opa} - {1'b0, req_i.opb} - {8'h00, cin};
							s5 = {1'b0, req_i.opa[3:0]} - {1'b0, req_i.opb[3:0]} - {4'h0, cin};
							nxt_status[`CDM_OVF] = (req_i.opa[7] != req_i.opb[7]) &&
								(s9[7] != req_i.opa[7]);
							nxt_rsp.data = s9[7:0];
						end
						ALU_PROD: begin
							prod = {8'h00, req_i.opa} * {8'h00, req_i.opb};
							nxt_status[`CDM_OVF] = prod > `CDM_BYTE_MAX;
							nxt_rsp.data = prod[7:0];
							nxt_rsp.data_hi = prod[15:8];
						end
						ALU_DIV: begin
							// quotient and remainder read zero on a zero divisor
							nxt_status[`CDM_OVF] = (req_i.opb == 8'h00);
							if (req_i.opb != 8'h00) begin
								nxt_rsp.data = req_i.opa / req_i.opb;
								nxt_rsp.data_hi = req_i.opa % req_i.opb;
							end
						end
						default: begin
							s9 = {1'b0, req_i.opa} + {1'b0, req_i.opb} + {8'h00, cin};
							s5 = {1'b0, req_i.opa[3:0]} + {1'b0, req_i.opb[3:0]} + {4'h0, cin};
							nxt_status[`CDM_OVF] = (req_i.opa[7] == req_i.opb[7]) &&
								(s9[7] != req_i.opa[7]);
							nxt_rsp.data = s9[7:0];
						end
					endcase
					// product and divide leave s9 and s5 zero, so both carries clear
					nxt_status[`CDM_CARRY] = s9[8];
					nxt_status[`CDM_AUX] = s5[4];
				end
				OP_CODE_RD: begin
					nxt_fl.valid = 1'b1;
					nxt_fl.addr = req_i.xaddr;
					nxt_fl.lock_hit = (req_i.xaddr == lock_a);
				end
				OP_XRD: begin
					nxt_rsp.data = exp_ram_ff[req_i.xaddr[7:0]];
				end
				OP_XWR: begin
					if (flash_wen_i) begin
						nxt_fl.valid = 1'b1;
						nxt_fl.we = 1'b1;
						nxt_fl.addr = req_i.xaddr;
						nxt_fl.wdata = req_i.wdata;
						nxt_fl.lock_hit = (req_i.xaddr == lock_a);
					end else begin
						xwe = 1'b1;
						xwa = req_i.xaddr[7:0];
						xwd = req_i.wdata;
					end
				end
				default: begin
					nxt_rsp.valid = 1'b0;
				end
			endcase
		end
		// parity follows the accumulator every cycle
		nxt_status[`CDM_PAR] = ^acc_i;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			status_ff <= `CDM_STATUS_RST;
			stack_ptr_ff <= `CDM_STACK_RST;
			rsp_ff <= '0;
			sfr_ff <= '0;
			fl_ff <= '0;
		end else begin
			status_ff <= nxt_status;
			stack_ptr_ff <= nxt_stack_ptr;
			rsp_ff <= nxt_rsp;
			sfr_ff <= nxt_sfr;
			fl_ff <= nxt_fl;
		end
	end

	// ram contents are not reset, as in any scratch memory
	always_ff @(posedge mclk_i) begin
		if (iwe) begin
			iram_ff[iwa] <= iwd;
		end
		if (xwe) begin
			exp_ram_ff[xwa] <= xwd;
		end
	end

	assign rsp_o = rsp_ff;
	assign sfr_o = sfr_ff;
	assign flash_o = fl_ff;
	assign status_o = status_ff;
	assign stack_ptr_o = stack_ptr_ff;

	logic status_hit;
	assign status_hit = req_i.valid && (((req_i.op == OP_WR) && (req_i.am == AM_DIRECT) &&
		(req_i.addr == `CDM_STATUS_ADDR)) ||
		((req_i.op == OP_BIT_WR) && (byte_a == `CDM_STATUS_ADDR)));

	sequence s_push;
		req_i.valid && req_i.op == OP_PUSH;
	endsequence
	sequence s_arith(cdm_alu_t k);
		req_i.valid && req_i.op == OP_ARITH && req_i.alu == k;
	endsequence

	a_push_inc: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_push |=> stack_ptr_ff == $past(stack_ptr_ff) + 8'h01)
		else $error("push did not increment pointer");
	a_pop_dec: assert property (@(posedge mclk_i) disable iff (rst_i)
		req_i.valid && req_i.op == OP_POP |=> stack_ptr_ff == $past(stack_ptr_ff) - 8'h01)
		else $error("pop did not decrement pointer");
	a_parity_track: assert property (@(posedge mclk_i) disable iff (rst_i)
		##1 status_o[`CDM_PAR] == ^$past(acc_i)) else $error("parity bit wrong");
	a_div_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_arith(ALU_DIV) ##0 (req_i.opb == 8'h00) |=>
		status_o[`CDM_OVF] && !status_o[`CDM_CARRY])
		else $error("divide by zero missed overflow");
	a_mul_ovf: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_arith(ALU_PROD) |=>
		status_o[`CDM_OVF] == ($past(req_i.opa) * $past(req_i.opb) > 255))
		else $error("product overflow wrong");
	a_add_carry: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_arith(ALU_ADD) |=>
		status_o[`CDM_CARRY] == ($past(req_i.opa) + $past(req_i.opb) > 255))
		else $error("add carry wrong");
	a_direct_sfr: assert property (@(posedge mclk_i) disable iff (rst_i)
		req_i.valid && req_i.op == OP_RD && req_i.am == AM_DIRECT && req_i.addr[7] &&
		req_i.addr != `CDM_STATUS_ADDR && req_i.addr != `CDM_STACK_ADDR |=>
		rsp_o.foreign && sfr_o.valid)
		else $error("direct upper access not sent to sfr");
	a_indirect_ram: assert property (@(posedge mclk_i) disable iff (rst_i)
		req_i.valid && req_i.op == OP_RD && req_i.am == AM_INDIRECT |=> !rsp_o.foreign && !sfr_o.valid)
		else $error("indirect access left ram");
	a_user_flags: assert property (@(posedge mclk_i) disable iff (rst_i)
		!status_hit |=> $stable(status_o[`CDM_UFLAG0]) && $stable(status_o[`CDM_UFLAG1]))
		else $error("user flag changed by hardware");
	a_code_flash: assert property (@(posedge mclk_i) disable iff (rst_i)
		req_i.valid && req_i.op == OP_CODE_RD |=> flash_o.valid && !flash_o.we)
		else $error("code read not sent to flash");
endmodule // cdm_core

// >>> hdl/cdm_pkg.sv
// types for the status word and data memory map block
package cdm_pkg;
	typedef enum logic [3:0] {OP_NONE, OP_RD, OP_WR, OP_BIT_RD, OP_BIT_WR, OP_PUSH, OP_POP,
		OP_ARITH, OP_CODE_RD, OP_XRD, OP_XWR} cdm_op_t;
	typedef enum logic [1:0] {AM_DIRECT, AM_INDIRECT, AM_REG} cdm_am_t;
	typedef enum logic [2:0] {ALU_ADD, ALU_ADD_CY, ALU_SUB_BR, ALU_PROD, ALU_DIV} cdm_alu_t;
	typedef enum logic [1:0] {FSZ_16K, FSZ_8K, FSZ_4K} cdm_fsz_t;
	typedef struct packed {
		logic valid;
		cdm_op_t op;
		cdm_am_t am;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic bit_val;
		cdm_alu_t alu;
		logic [7:0] opa;
		logic [7:0] opb;
		logic [15:0] xaddr;
	} cdm_req_t;
	typedef struct packed {
		logic valid;
		logic foreign;
		logic bit_val;
		logic [7:0] data;
		logic [7:0] data_hi;
	} cdm_rsp_t;
	typedef struct packed {
		logic valid;
		logic we;
		logic is_bit;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic bit_val;
		logic lock_hit;
	} cdm_ext_t;
endpackage

// >>> tb/cdm_dp_model.sv
// datapath model issuing requests to the memory map block
`timescale 1ns/1ps
module cdm_dp_model import cdm_pkg::*; (
	// clock
	input wire logic mclk_i,
	// request side
	output cdm_req_t req_o,
	output logic [7:0] acc_o,
	// answer side
	input wire cdm_rsp_t rsp_i
);
	initial begin
		req_o = '0;
		acc_o = 8'h00;
	end
	// one request, held over the taking edge, answer read at the next negedge
	task automatic issue(input cdm_req_t rq, output cdm_rsp_t rs);
		cdm_req_t drv;
		drv = rq;
		drv.valid = 1'b1;
		@(negedge mclk_i);
		req_o = drv;
		@(negedge mclk_i);
		rs = rsp_i;
		// released fields do not keep their last value
		drv = ~rq;
		drv.valid = 1'b0;
		req_o = drv;
	endtask
	// accumulator moves only at a falling edge, between requests
	task automatic set_acc(input logic [7:0] v);
		acc_o = v;
	endtask
endmodule // cdm_dp_model

// >>> tb/tb_cpu_status_and_data_memory_map.sv
// self-checking bench for the status word and data memory map block
`timescale 1ns/1ps
module tb_cpu_status_and_data_memory_map import cdm_pkg::*; ;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic flash_wen_i = 1'b0;
	cdm_fsz_t fsz_i = FSZ_16K;
	cdm_req_t req, rq;
	cdm_rsp_t rsp, rs;
	cdm_ext_t sfr, flash;
	logic [7:0] acc, status, stack_ptr;
	logic [18:0] ex;
	logic ecy = 1'b0;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int k;
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	cdm_dp_model dp (.mclk_i(mclk_i), .req_o(req), .acc_o(acc), .rsp_i(rsp));
	cdm_core uut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .acc_i(acc),
		.flash_wen_i(flash_wen_i), .fsz_i(fsz_i), .rsp_o(rsp), .sfr_o(sfr),
		.flash_o(flash), .status_o(status), .stack_ptr_o(stack_ptr));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic go(input cdm_op_t op, input cdm_am_t am, input logic [7:0] a, d);
		rq = '0;
		rq.op = op;
		rq.am = am;
		rq.addr = a;
		rq.wdata = d;
		rq.bit_val = d[0];
		dp.issue(rq, rs);
	endtask
	// returns {carry, aux carry, overflow, data, data_hi}
	function automatic logic [18:0] arith(input cdm_alu_t f, input logic [7:0] a, b,
		input logic c);
		logic [8:0] s;
		logic [4:0] n;
		logic [15:0] p;
		logic ci;
		ci = (f == ALU_ADD) ? 1'b0 : c;
		p = a * b;
		case (f)
			ALU_ADD, ALU_ADD_CY: begin
				s = a + b + ci;
				n = a[3:0] + b[3:0] + ci;
				return {s[8], n[4], a[7] == b[7] && s[7] != a[7], s[7:0], 8'h00};
			end
			ALU_SUB_BR: begin
				s = {1'b0, a} - b - ci;
				n = {1'b0, a[3:0]} - b[3:0] - ci;
				return {s[8], n[4], a[7] != b[7] && s[7] != a[7], s[7:0], 8'h00};
			end
			ALU_PROD: return {2'b00, p > 255, p[7:0], p[15:8]};
			default: return (b == 0) ? 19'h1_0000 : {3'b000, a / b, a % b};
		endcase
	endfunction
	// hang guard, far above the roughly 190 cycles the run needs
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		void'($urandom(32'h9c27));
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i);
		chk({status, stack_ptr}, 16'h0007);
		rst_i = 1'b0;
		go(OP_PUSH, AM_DIRECT, 8'h00, 8'hab);
		chk({rs.valid, stack_ptr}, 9'h108);
		go(OP_RD, AM_DIRECT, 8'h08, 8'h00);
		chk(rs.data, 8'hab);
		go(OP_POP, AM_DIRECT, 8'h00, 8'h00);
		chk({rs.data, stack_ptr}, 16'hab07);
		go(OP_WR, AM_DIRECT, 8'h81, 8'h00);
		go(OP_POP, AM_DIRECT, 8'h00, 8'h00);
		chk(stack_ptr, 8'hff);
		go(OP_WR, AM_DIRECT, 8'hd0, 8'h18);
		chk(status, 8'h18);
		go(OP_WR, AM_REG, 8'h00, 8'h90);
		go(OP_RD, AM_DIRECT, 8'h18, 8'h00);
		chk(rs.data, 8'h90);
		go(OP_WR, AM_INDIRECT, 8'h00, 8'h5a);
		chk(sfr.valid, 1'b0);
		go(OP_RD, AM_INDIRECT, 8'h00, 8'h00);
		chk(rs.data, 8'h5a);
		// second index register points elsewhere, at 0xc4 rather than 0x90, and the write and the read both go through it
		go(OP_WR, AM_REG, 8'h01, 8'hc4);
		go(OP_WR, AM_INDIRECT, 8'h01, 8'h66);
		go(OP_RD, AM_INDIRECT, 8'h01, 8'h00);
		chk(rs.data, 8'h66);
		go(OP_RD, AM_DIRECT, 8'h90, 8'h00);
		chk({rs.foreign, sfr.valid, sfr.addr}, 18'h3_0090);
		go(OP_WR, AM_DIRECT, 8'h90, 8'h3c);
		chk({sfr.valid, sfr.we, sfr.is_bit, sfr.wdata}, 11'h63c);
		go(OP_BIT_WR, AM_DIRECT, 8'h8b, 8'h01);
		chk({sfr.valid, sfr.we, sfr.is_bit, sfr.bit_val, sfr.addr}, 20'hf_008b);
		go(OP_WR, AM_DIRECT, 8'hd0, 8'h23);
		chk(status, 8'h22);
		go(OP_BIT_WR, AM_DIRECT, 8'hd5, 8'h00);
		go(OP_BIT_WR, AM_DIRECT, 8'hd0, 8'h01);
		chk(status, 8'h02);
		go(OP_BIT_RD, AM_DIRECT, 8'hd1, 8'h00);
		chk(rs.bit_val, 1'b1);
		go(OP_BIT_WR, AM_DIRECT, 8'hd5, 8'h01);
		chk(status, 8'h22);
		go(OP_WR, AM_DIRECT, 8'h22, 8'h00);
		go(OP_BIT_WR, AM_DIRECT, 8'h13, 8'h01);
		go(OP_RD, AM_DIRECT, 8'h22, 8'h00);
		chk(rs.data, 8'h08);
		go(OP_BIT_RD, AM_DIRECT, 8'h13, 8'h00);
		chk(rs.bit_val, 1'b1);
		// first five are corners: signed overflow, product over a byte, zero divisor
		for (k = 0; k < 60; k++) begin
			rq = '0;
			rq.op = OP_ARITH;
			rq.alu = cdm_alu_t'(k < 5 ? 3'(k) : 3'($urandom_range(4)));
			rq.opa = k < 5 ? 8'h80 : 8'($urandom);
			rq.opb = k < 4 ? 8'h80 : (k == 4 ? 8'h00 : 8'($urandom));
			dp.set_acc(8'($urandom));
			ex = arith(rq.alu, rq.opa, rq.opb, ecy);
			dp.issue(rq, rs);
			chk({status[7:6], status[2]}, ex[18:16]);
			chk(rs.data, ex[15:8]);
			if (rq.alu inside {ALU_PROD, ALU_DIV}) chk(rs.data_hi, ex[7:0]);
			chk({status[5], status[1], status[0]}, {2'b11, ^acc});
			ecy = ex[18];
		end
		for (k = 0; k < 3; k++) begin
			fsz_i = cdm_fsz_t'(k);
			rq = '0;
			rq.op = OP_CODE_RD;
			rq.xaddr = k == 0 ? 16'h3fff : (k == 1 ? 16'h1fff : 16'h0fff);
			dp.issue(rq, rs);
			chk({flash.valid, flash.we, flash.lock_hit, flash.addr}, {3'b101, rq.xaddr});
		end
		flash_wen_i = 1'b1;
		rq = '0;
		rq.op = OP_XWR;
		rq.xaddr = 16'h0010;
		rq.wdata = 8'h3c;
		dp.issue(rq, rs);
		chk({flash.valid, flash.we, flash.lock_hit, flash.addr, flash.wdata}, 27'h600_103c);
		flash_wen_i = 1'b0;
		dp.issue(rq, rs);
		chk(flash.valid, 1'b0);
		rq.op = OP_XRD;
		dp.issue(rq, rs);
		chk(rs.data, 8'h3c);
		results();
	end
endmodule // tb_cpu_status_and_data_memory_map
